// ### bench/pmc_checker.sv
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: One clock, reset asynchronous and active low.
// Notes:   Bound to every pmc_regs instance at the foot of this file.
`include "pmc_defines.svh"
module pmc_checker (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic [31:0] O_WB_DAT,
    input wire logic i_deconfigure,
    input wire logic i_resume_done,
    input wire logic i_resume_remote,
    input wire logic i_resume_by_lan,
    input wire logic O_PHY_RESET,
    input wire logic O_USB_NAK,
    input wire logic [1:0] O_SLEEP_STATE,
    input wire logic O_CLR_FRAME_FLAGS
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Helper logic and assertions.
    // ------------------------------------------------------------------
    localparam int HOLD = `PMC_PHYRST_CYC;
    logic [`PMC_CNT_W-1:0] hold_cnt;
    logic req;
    assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;

    // Counts the cycles for which the PHY has been held in reset.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) hold_cnt <= 24'h0;
        else if (O_PHY_RESET) hold_cnt <= hold_cnt + 24'h1;
        else hold_cnt <= 24'h0;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    a_ack_answers: assert property (req |=> O_WB_ACK) else $error("request not acked");
    a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
    a_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("data off ack");
    a_nak_held: assert property (O_PHY_RESET |-> O_USB_NAK) else $error("no nak");
    a_phy_hold: assert property ($fell(O_PHY_RESET) |-> hold_cnt >= HOLD)
        else $error("PHY reset too short");
    a_phy_cause: assert property ($rose(O_PHY_RESET) |-> $past(req && I_WB_WE
        && I_WB_ADR == `PMC_OFS_PMCTL && I_WB_SEL[0] && I_WB_DAT[`PMC_BIT_PHYRST]))
        else $error("PHY reset without write");
    a_clr_cause: assert property (O_CLR_FRAME_FLAGS |-> $past(i_resume_done
        && i_resume_remote && i_resume_by_lan)) else $error("flag clear without lan resume");
    a_clr_single: assert property (O_CLR_FRAME_FLAGS |=> !O_CLR_FRAME_FLAGS)
        else $error("flag clear too long");
    a_deconf_sleep: assert property (i_deconfigure |-> ##2 O_SLEEP_STATE == 2'h2)
        else $error("sleep state not reset");
endmodule : pmc_checker

bind pmc_regs pmc_checker pmc_checker_i (.I_CLK, .I_RSTN, .I_WB_CYC, .I_WB_STB, .I_WB_WE,
    .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_ACK, .O_WB_DAT, .i_deconfigure, .i_resume_done,
    .i_resume_remote, .i_resume_by_lan, .O_PHY_RESET, .O_USB_NAK, .O_SLEEP_STATE,
    .O_CLR_FRAME_FLAGS);

// ### bench/pmc_env.sv
// Purpose: Model of the board around the bank: configuration, PHY clocks, watchdog.
// Assumes: Counts cycles of the system clock from reset release.
// Notes:   PHY clocks come late, so ready must come from the watchdog first.
module pmc_env (
    input wire logic clk,
    input wire logic rstn,
    output logic config_done,
    output logic phy_clk_ok,
    output logic watchdog_expired
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] cnt;

    // Free-running age counter that saturates.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cnt <= 12'h0;
        else if (cnt != 12'hfff) cnt <= cnt + 12'h1;
    end

    // Levels derived from the age; clocks absent until well after the watchdog.
    assign config_done = cnt >= 12'h014;
    assign watchdog_expired = cnt >= 12'h12c;
    assign phy_clk_ok = cnt >= 12'h5dc;
endmodule : pmc_env

// ### bench/tb.sv
// Purpose: Register-level test of the power management bank over Wishbone.
// Assumes: Interrupt mask bits set to one block their status bit.
// Notes:   The 2 ms PHY hold is too long to run out here; only its start is seen.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, ack, irq, phy_reset_pulse, nak, clr, push, pop, conf, deconf, susp;
    logic ev_ed, ev_lan, rdone, rrem, rlan, cfg_done, phy_ok, wdog;
    logic [15:0] pushn, popn;
    logic [31:0] rdat, q;
    logic [1:0] sleep;
    pmc_pkg::pmc_wb_req_t rq;
    int n_fail, samples_checked, n_clr;

    pmc_regs pmc_regs_i (.I_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(rq.cyc), .I_WB_STB(rq.stb),
        .I_WB_WE(rq.we), .I_WB_ADR(rq.adr), .I_WB_SEL(rq.sel), .I_WB_DAT(rq.dat),
        .O_WB_ACK(ack), .O_WB_DAT(rdat), .i_tx_push(push), .i_tx_push_bytes(pushn),
        .i_tx_pop(pop), .i_tx_pop_bytes(popn), .i_config_done(cfg_done),
        .i_phy_clk_ok(phy_ok), .i_watchdog_expired(wdog), .i_configured(conf),
        .i_deconfigure(deconf), .i_suspend_entry(susp), .i_energy_event(ev_ed),
        .i_lan_event(ev_lan), .i_resume_done(rdone), .i_resume_remote(rrem),
        .i_resume_by_lan(rlan), .O_PHY_RESET(phy_reset_pulse), .O_USB_NAK(nak),
        .O_SLEEP_STATE(sleep), .O_CLR_FRAME_FLAGS(clr), .O_IRQ(irq));
    pmc_env pmc_env_i (.clk(clk), .rstn(rstn), .config_done(cfg_done), .phy_clk_ok(phy_ok),
        .watchdog_expired(wdog));

    // Clock of 100 MHz.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Counts flag-clear pulses, each standing for one cycle.
    always @(negedge clk) begin
        if (clr === 1'h1) n_clr++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task tally_and_finish;
        $display("compares %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // One classic cycle; holds the request until ack is sampled high at a rising edge.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rq <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hf, dat: d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (ack !== 1'h1) begin
            n_fail++;
            tally_and_finish();
        end
        q = rdat;
        rq <= '0;
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'h0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task settle;
        repeat (3) @(negedge clk);
    endtask : settle

    task rsm(input logic r, input logic l);
        @(posedge clk);
        {rdone, rrem, rlan} <= {1'h1, r, l};
        @(posedge clk);
        rdone <= 1'h0;
        settle();
    endtask : rsm

    // Energy or line event held long enough to pass the input synchroniser.
    task ev(input logic lan, input logic arm);
        @(posedge clk);
        susp <= arm;
        @(posedge clk);
        susp <= 1'h0;
        if (lan) ev_lan <= 1'h1;
        else ev_ed <= 1'h1;
        repeat (6) @(posedge clk);
        {ev_lan, ev_ed} <= 2'h0;
        settle();
    endtask : ev

    // Main sequence.
    initial begin
        int n;
        rq = '0;
        {rstn, push, pop, conf, deconf, susp, ev_ed, ev_lan, rdone, rrem, rlan} = 11'h0;
        pushn = 16'h0;
        popn = 16'h0;
        n_fail = 0;
        samples_checked = 0;
        n_clr = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        rd(8'h1c, 32'h2000);
        rd(8'h20, 32'h140);
        rd(8'h30, 32'h0);
        rd(8'h2c, 32'h0);
        wb(1'h1, 8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h2000);
        @(posedge clk);
        {push, pushn} <= {1'h1, 16'h0300};
        @(posedge clk);
        {push, pop, popn} <= {2'h1, 16'h0100};
        @(posedge clk);
        pop <= 1'h0;
        rd(8'h1c, 32'h1e00);
        {pop, popn} <= {1'h1, 16'h0400};
        @(posedge clk);
        pop <= 1'h0;
        rd(8'h1c, 32'h2000);
        repeat (40) @(posedge clk);
        rd(8'h20, 32'h140);
        n = 0;
        do begin
            wb(1'h0, 8'h20, 32'h0);
            n++;
        end while (q[7] !== 1'h1 && n < 200);
        chk(q, 32'h1c0);
        settle();
        chk({31'h0, irq}, 32'h1);
        wb(1'h1, 8'h2c, 32'hf);
        settle();
        chk({31'h0, irq}, 32'h0);
        wb(1'h1, 8'h2c, 32'h0);
        wb(1'h1, 8'h28, 32'hf);
        rd(8'h28, 32'h0);
        chk({31'h0, irq}, 32'h0);
        conf <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            wb(1'h1, 8'h20, 32'h100 | (c << 5));
            settle();
            chk({30'h0, sleep}, c);
        end
        @(posedge clk);
        {deconf, conf} <= 2'h2;
        @(posedge clk);
        deconf <= 1'h0;
        settle();
        chk({30'h0, sleep}, 32'h2);
        rd(8'h20, 32'h1c0);
        ev(1'h0, 1'h1);
        rd(8'h20, 32'h1c0);
        wb(1'h1, 8'h20, 32'h14c);
        ev(1'h0, 1'h1);
        rd(8'h20, 32'h1cd);
        chk({31'h0, irq}, 32'h1);
        ev(1'h1, 1'h0);
        rd(8'h20, 32'h1cf);
        wb(1'h1, 8'h20, 32'h14d);
        rd(8'h20, 32'h1cc);
        ev(1'h0, 1'h1);
        ev(1'h1, 1'h0);
        wb(1'h1, 8'h20, 32'h34c);
        rsm(1'h0, 1'h0);
        rd(8'h20, 32'h3cf);
        rsm(1'h1, 1'h0);
        rd(8'h20, 32'h3c3);
        chk(n_clr, 32'h0);
        wb(1'h1, 8'h20, 32'h34c);
        rsm(1'h1, 1'h1);
        rd(8'h20, 32'h3c1);
        chk(n_clr, 32'h1);
        wb(1'h1, 8'h20, 32'h350);
        settle();
        chk({30'h0, phy_reset_pulse, nak}, 32'h3);
        wb(1'h1, 8'h20, 32'h340);
        rd(8'h20, 32'h3d1);
        chk({31'h0, phy_reset_pulse}, 32'h1);
        tally_and_finish();
    end
endmodule : tb

// ### core/pmc_regs.sv
// Purpose: Transmit free-space and power management control registers,
//          reached over classic Wishbone, with a wake interrupt.
// Assumes: One 100 MHz clock; outside-domain inputs pass three flops.
// Notes:   Every output comes straight from a flip-flop.
//
// Register access over Wishbone is this design's own decision.
`include "pmc_defines.svh"

module pmc_regs (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic O_WB_ACK,
    output logic [31:0] O_WB_DAT,
    input wire logic i_tx_push,
    input wire logic [15:0] i_tx_push_bytes,
    input wire logic i_tx_pop,
    input wire logic [15:0] i_tx_pop_bytes,
    input wire logic i_config_done,
    input wire logic i_phy_clk_ok,
    input wire logic i_watchdog_expired,
    input wire logic i_configured,
    input wire logic i_deconfigure,
    input wire logic i_suspend_entry,
    input wire logic i_energy_event,
    input wire logic i_lan_event,
    input wire logic i_resume_done,
    input wire logic i_resume_remote,
    input wire logic i_resume_by_lan,
    output logic O_PHY_RESET,
    output logic O_USB_NAK,
    output logic [1:0] O_SLEEP_STATE,
    output logic O_CLR_FRAME_FLAGS,
    output logic O_IRQ
);

    // ------------------------------------------------------------------
    // State of the block.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`PMC_PIN_N-1:0] sync1;
        logic [`PMC_PIN_N-1:0] sync2;
        logic [`PMC_PIN_N-1:0] sync3;
        logic [`PMC_PIN_N-1:0] pin_lvl;
        logic [15:0] tx_free;
        logic rcws;
        logic rcwe;
        logic ready;
        logic [1:0] susp;
        logic phy_reset_pulse;
        logic [`PMC_CNT_W-1:0] phy_cnt;
        logic lan_wake_enable;
        logic energy_detect_wake_enable;
        logic arm_wol;
        logic arm_ed;
        logic [1:0] wake_cause;
        logic [`PMC_IRQ_W-1:0] irq_sts;
        logic [`PMC_IRQ_W-1:0] irq_mask;
        logic ack;
        logic [31:0] rdat;
        logic nak;
        logic [1:0] sleep;
        logic clr_frame;
        logic irq;
        pmc_pkg::pmc_phase_t phase;
    } pmc_state_t;

    pmc_state_t st_reg;
    pmc_state_t st_next;
    pmc_pkg::pmc_wb_req_t req;
    pmc_pkg::pmc_resume_t res;
    logic [`PMC_PIN_N-1:0] pin_raw;
    logic [`PMC_PIN_N-1:0] pin_agree;
    logic [`PMC_PIN_N-1:0] pin_rise;
    logic phy_go;

    // Bus and resume signals gathered into their carriers.
    assign req = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, adr: I_WB_ADR,
                   sel: I_WB_SEL, dat: I_WB_DAT};
    assign res = '{done: i_resume_done, remote: i_resume_remote, by_lan: i_resume_by_lan};

    // ------------------------------------------------------------------
    // Inputs from outside the clock domain.
    // ------------------------------------------------------------------
    // The energy and line events, the PHY clock status and the watchdog
    // arrive from other domains.  Each passes three flip-flops; the first
    // stage may go metastable, so only the second and third are looked at.
    // A new level is accepted once those two agree, which also rejects a
    // one-cycle glitch that slips through the first stage.
    assign pin_raw[`PMC_PIN_ED] = i_energy_event;
    assign pin_raw[`PMC_PIN_LAN] = i_lan_event;
    assign pin_raw[`PMC_PIN_PCLK] = i_phy_clk_ok;
    assign pin_raw[`PMC_PIN_WDG] = i_watchdog_expired;

    // Stages two and three hold the same value.
    assign pin_agree = ~(st_reg.sync2 ^ st_reg.sync3);

    // A filtered level that goes from low to high is one event.  The
    // filtered level resets low, the idle level of every pin, so no false
    // edge follows reset.
    assign pin_rise = pin_agree & st_reg.sync3 & ~st_reg.pin_lvl;

    // The reset sequence may finish once PHY clocks run, or once the
    // watchdog has given up waiting for them.
    assign phy_go = st_reg.pin_lvl[`PMC_PIN_PCLK] || st_reg.pin_lvl[`PMC_PIN_WDG];

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // Computes every register, the bus answer and the outputs.
    // Later assignments below override earlier ones, so the order sets the
    // priority: software writes, then wake sets, then resume clears, then
    // deconfiguration.  The interrupt status takes its events last of all.
    always_comb begin
        logic acc;
        logic wr_pm;
        logic wr_irq;
        logic [15:0] sum;
        logic [1:0] wset;
        logic [`PMC_IRQ_W-1:0] ev;
        acc = 1'b0;
        wr_pm = 1'b0;
        wr_irq = 1'b0;
        sum = 16'h0000;
        wset = 2'h0;
        ev = '0;
        st_next = st_reg;
        // Synchroniser chains advance every cycle; stage one feeds only stage two.
        st_next.sync1 = pin_raw;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        // The filtered level follows stage three only while two and three agree.
        st_next.pin_lvl = (pin_agree & st_reg.sync3) | (~pin_agree & st_reg.pin_lvl);

        // Free space: drain adds, push subtracts, clamped to capacity.
        // A drain and a push in one cycle both count; the drain is applied
        // first, so a full FIFO can take a push in the cycle that it drains.
        sum = st_reg.tx_free;
        if (i_tx_pop) begin
            if (i_tx_pop_bytes > (`PMC_TX_CAP - sum)) begin
                sum = `PMC_TX_CAP;
            end else begin
                sum = 16'(sum + i_tx_pop_bytes);
            end
        end
        if (i_tx_push) begin
            sum = (i_tx_push_bytes > sum) ? 16'h0000 : 16'(sum - i_tx_push_bytes);
        end
        st_next.tx_free = sum;

        // Wishbone slave: one-cycle answer, ack drops the cycle after.
        // A request is taken only while ack is low, so a master that holds
        // its strobe through the ack cycle is never answered twice.
        acc = req.cyc && req.stb && !st_reg.ack;
        st_next.ack = acc;
        st_next.rdat = 32'h0000_0000;
        if (acc && !req.we) begin
            case (req.adr)
                `PMC_OFS_TXFREE: st_next.rdat = {16'h0000, st_reg.tx_free};
                `PMC_OFS_PMCTL: begin
                    st_next.rdat[`PMC_BIT_RCWS] = st_reg.rcws;
                    st_next.rdat[`PMC_BIT_RCWE] = st_reg.rcwe;
                    st_next.rdat[`PMC_BIT_READY] = st_reg.ready;
                    st_next.rdat[`PMC_SUSP_HI:`PMC_SUSP_LO] = st_reg.susp;
                    st_next.rdat[`PMC_BIT_PHYRST] = st_reg.phy_reset_pulse;
                    st_next.rdat[`PMC_BIT_WOL] = st_reg.lan_wake_enable;
                    st_next.rdat[`PMC_BIT_ED] = st_reg.energy_detect_wake_enable;
                    st_next.rdat[`PMC_WC_HI:`PMC_WC_LO] = st_reg.wake_cause;
                end
                `PMC_OFS_IRQ_STS: st_next.rdat[`PMC_IRQ_W-1:0] = st_reg.irq_sts;
                `PMC_OFS_IRQ_MASK: st_next.rdat[`PMC_IRQ_W-1:0] = st_reg.irq_mask;
                default: st_next.rdat = 32'h0000_0000;
            endcase
        end
        wr_pm = acc && req.we && (req.adr == `PMC_OFS_PMCTL);
        wr_irq = acc && req.we && (req.adr == `PMC_OFS_IRQ_STS);

        // Software writes to the power management control register.
        // Bits 9:8 sit in byte lane one and bits 7:0 in lane zero; the other
        // lanes hold only reserved bits and are ignored.
        if (wr_pm && req.sel[1]) begin
            st_next.rcws = req.dat[`PMC_BIT_RCWS];
            st_next.rcwe = req.dat[`PMC_BIT_RCWE];
        end
        if (wr_pm && req.sel[0]) begin
            st_next.susp = req.dat[`PMC_SUSP_HI:`PMC_SUSP_LO];
            st_next.lan_wake_enable = req.dat[`PMC_BIT_WOL];
            st_next.energy_detect_wake_enable = req.dat[`PMC_BIT_ED];
            if (req.dat[`PMC_WC_HI] || req.dat[`PMC_WC_LO]) begin
                st_next.wake_cause = `PMC_WC_NONE;
            end
        end
        if (acc && req.we && req.adr == `PMC_OFS_IRQ_MASK && req.sel[0]) begin
            st_next.irq_mask = req.dat[`PMC_IRQ_W-1:0];
        end

        // Enables are captured on entry to the reduced-power state.
        // Arming copies the enables, so a change of the enable bits while
        // asleep does not alter which sources may set the cause.
        if (i_suspend_entry) begin
            st_next.arm_wol = st_reg.lan_wake_enable;
            st_next.arm_ed = st_reg.energy_detect_wake_enable;
        end
        // Wake events set the cause only for sources armed before sleep.
        wset[`PMC_WC_LO] = st_reg.arm_ed && pin_rise[`PMC_PIN_ED];
        wset[`PMC_WC_HI] = st_reg.arm_wol && pin_rise[`PMC_PIN_LAN];
        // An event that finds a cause already recorded reports multiple events.
        // A set in the same cycle as a software clear wins, so none is lost.
        if (wset != 2'h0) begin
            if (st_next.wake_cause != `PMC_WC_NONE || wset == `PMC_WC_MULTI) begin
                st_next.wake_cause = `PMC_WC_MULTI;
            end else begin
                st_next.wake_cause = wset;
            end
            ev[`PMC_IRQ_WAKE] = 1'b1;
        end

        // Resume completion: status and enable clearing.
        // Only a remote resume caused by a frame or packet clears the wake
        // cause, and only its LAN bit; a host resume leaves the wake cause and enables as they were.
        st_next.clr_frame = 1'b0;
        if (res.done) begin
            ev[`PMC_IRQ_RESUME] = 1'b1;
            if (st_reg.rcws && res.remote && res.by_lan) begin
                st_next.clr_frame = 1'b1;
                st_next.wake_cause[`PMC_WC_HI] = 1'b0;
            end
            if (st_reg.rcwe && res.remote) begin
                st_next.lan_wake_enable = 1'b0;
                st_next.energy_detect_wake_enable = 1'b0;
                st_next.arm_wol = 1'b0;
                st_next.arm_ed = 1'b0;
            end
        end

        // Deconfiguration returns to unconfigured with suspend field 10b.
        if (i_deconfigure) begin
            st_next.susp = `PMC_SUSP_DEF;
        end
        // Unconfigured operation is limited to state 2; software keeps to it.
        // Code 11 selects state 3 on this variant of the part.
        st_next.sleep = (st_reg.susp == `PMC_SUSP_S3) ?
                        {1'b1, `PMC_SLEEP_MAX_V3} : st_reg.susp;

        // Phase machine: ready, PHY reset hold and NAK.
        // INIT waits for configuration and a finished reset; NORMAL accepts a
        // PHY reset request; PHY_WAIT counts the minimum hold and then waits
        // for PHY clocks or the watchdog before it releases PHY and bus NAK.
        case (st_reg.phase)
            pmc_pkg::PMC_INIT: begin
                if (i_config_done && phy_go) begin
                    st_next.phase = pmc_pkg::PMC_NORMAL;
                    st_next.ready = 1'b1;
                    ev[`PMC_IRQ_READY] = 1'b1;
                end
            end
            pmc_pkg::PMC_NORMAL: begin
                if (!i_configured && i_deconfigure) begin
                    st_next.ready = 1'b1;
                end
                if (wr_pm && req.sel[0] && req.dat[`PMC_BIT_PHYRST]) begin
                    st_next.phy_reset_pulse = 1'b1;
                    st_next.phy_cnt = '0;
                    st_next.nak = 1'b1;
                    st_next.phase = pmc_pkg::PMC_PHY_WAIT;
                end
            end
            pmc_pkg::PMC_PHY_WAIT: begin
                // Writes to the bit are ignored while it reads high.
                st_next.phy_reset_pulse = 1'b1;
                // The counter stops at the end of the hold, so a missing PHY
                // clock cannot make it wrap and shorten a later hold.
                if (st_reg.phy_cnt < `PMC_CNT_W'(`PMC_PHYRST_CYC - 1)) begin
                    st_next.phy_cnt = `PMC_CNT_W'(st_reg.phy_cnt + 1'b1);
                end else if (phy_go) begin
                    st_next.phy_reset_pulse = 1'b0;
                    st_next.nak = 1'b0;
                    st_next.phase = pmc_pkg::PMC_NORMAL;
                    ev[`PMC_IRQ_PHYDONE] = 1'b1;
                end
            end
            default: st_next.phase = pmc_pkg::PMC_INIT;
        endcase

        // Sticky interrupt status: set wins over write-one-to-clear.
        if (wr_irq && req.sel[0]) begin
            st_next.irq_sts = st_reg.irq_sts & ~req.dat[`PMC_IRQ_W-1:0];
        end
        st_next.irq_sts = st_next.irq_sts | ev;
        // A mask bit at one keeps its status bit off the interrupt line.
        st_next.irq = |(st_next.irq_sts & ~st_next.irq_mask);
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    // Holds all state; reset gives the register defaults.
    // The asynchronous reset branch loads constants only.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_reg <= '0;
            st_reg.tx_free <= `PMC_TX_CAP;
            st_reg.rcwe <= 1'b1;
            st_reg.susp <= `PMC_SUSP_DEF;
            st_reg.sleep <= `PMC_SUSP_DEF;
            st_reg.phase <= pmc_pkg::PMC_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops.
    assign O_WB_ACK = st_reg.ack;
    assign O_WB_DAT = st_reg.rdat;
    assign O_PHY_RESET = st_reg.phy_reset_pulse;
    assign O_USB_NAK = st_reg.nak;
    assign O_SLEEP_STATE = st_reg.sleep;
    assign O_CLR_FRAME_FLAGS = st_reg.clr_frame;
    assign O_IRQ = st_reg.irq;

endmodule : pmc_regs

// ### shared/pmc_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          power management control register bank.
// Assumes: 100 MHz system clock; classic Wishbone with 32-bit data.
// Notes:   Definitions only; included by bare name.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define PMC_ADDR_W 8
`define PMC_OFS_TXFREE 8'h1c
`define PMC_OFS_PMCTL 8'h20
`define PMC_OFS_IRQ_STS 8'h28
`define PMC_OFS_IRQ_MASK 8'h2c

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define PMC_TXFREE_W 16
`define PMC_TX_CAP 16'h2000
`define PMC_BIT_RCWS 9
`define PMC_BIT_RCWE 8
`define PMC_BIT_READY 7
`define PMC_SUSP_HI 6
`define PMC_SUSP_LO 5
`define PMC_BIT_PHYRST 4
`define PMC_BIT_WOL 3
`define PMC_BIT_ED 2
`define PMC_WC_HI 1
`define PMC_WC_LO 0
`define PMC_SUSP_DEF 2'h2
`define PMC_WC_NONE 2'h0
`define PMC_WC_ED 2'h1
`define PMC_WC_LAN 2'h2
`define PMC_WC_MULTI 2'h3
`define PMC_SLEEP_MAX_V3 1'b1
`define PMC_SUSP_S3 2'h3

// ----------------------------------------------------------------------
// Outside-domain inputs, one bit each in the synchroniser vectors.
// ----------------------------------------------------------------------
`define PMC_PIN_N 4
`define PMC_PIN_ED 0
`define PMC_PIN_LAN 1
`define PMC_PIN_PCLK 2
`define PMC_PIN_WDG 3

// ----------------------------------------------------------------------
// Interrupt status bits (same layout in the mask register).
// ----------------------------------------------------------------------
`define PMC_IRQ_W 4
`define PMC_IRQ_WAKE 0
`define PMC_IRQ_PHYDONE 1
`define PMC_IRQ_READY 2
`define PMC_IRQ_RESUME 3

// ----------------------------------------------------------------------
// Timing: PHY reset hold of 2 ms in whole cycles, clock MHz figure rounded down.
// ----------------------------------------------------------------------
`define PMC_CLK_HZ 100000000
`define PMC_PHYRST_US 2000
`define PMC_PHYRST_CYC ((`PMC_PHYRST_US * (`PMC_CLK_HZ / 1000000)))
`define PMC_CNT_W 24

`endif

// ### shared/pmc_pkg.sv
// Purpose: Types of the power management control register bank.
// Assumes: Constants come from pmc_defines.svh.
// Notes:   Nothing here is imported; users write pmc_pkg::name.
package pmc_pkg;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    // Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pmc_wb_req_t;

    // Resume completion event from the USB side.
    typedef struct packed {
        logic done;
        logic remote;
        logic by_lan;
    } pmc_resume_t;

    // Power phase of the device.
    typedef enum logic [1:0] {
        PMC_INIT,
        PMC_NORMAL,
        PMC_PHY_WAIT
    } pmc_phase_t;

endpackage : pmc_pkg
